// >>> src/mad_pkg.sv
// Constants and carrier types for the memory address decoder.
// Assumes a single system clock and an active-low asynchronous reset.
package mad_pkg;

    // ****************
    // Widths
    // ****************
    localparam int RF_AW = 12;             // Register-file address width
    localparam int PM_AW = 16;             // Program-space address width
    localparam int DW    = 8;              // Byte lane

    // ****************
    // Register-file map
    // ****************
    localparam logic [11:0] RF_RAM_BASE     = 12'h000;
    localparam logic [11:0] RF_CTL_BASE     = 12'hF00;
    localparam logic [11:0] RF_CTL_LAST     = 12'hFFF;
    localparam logic [11:0] RF_PAGE_SEL     = 12'hFF9;
    localparam int          PAGE_SEL_INFO   = 7;
    localparam logic [7:0]  PAGE_SEL_RESET  = 8'h00;
    localparam logic [7:0]  RF_UNDEF_VALUE  = 8'h00;
    localparam int          RF_BYTES        = 4096;
    localparam int          RAM_BYTES_DEF   = 1024;
    localparam int          RAM_BYTES_MIN   = 256;
    localparam int          RAM_BYTES_MAX   = 1024;

    // ****************
    // Program-space map
    // ****************
    localparam logic [15:0] PM_OPT_BASE     = 16'h0000;
    localparam logic [15:0] PM_RESET_VEC    = 16'h0002;
    localparam logic [15:0] PM_WDOG_VEC     = 16'h0004;
    localparam logic [15:0] PM_TRAP_VEC     = 16'h0006;
    localparam logic [15:0] PM_IRQ_BASE     = 16'h0008;
    localparam logic [15:0] PM_IRQ_LAST     = 16'h0037;
    localparam logic [15:0] PM_RSVD_BASE    = 16'h0038;
    localparam logic [15:0] PM_OSC_BASE     = 16'h003A;
    localparam logic [15:0] PM_OSC_LAST     = 16'h003D;
    localparam logic [15:0] PM_CODE_BASE    = 16'h003E;
    localparam logic [15:0] PM_INFO_BASE    = 16'hFE00;
    localparam logic [15:0] PM_INFO_LAST    = 16'hFF7F;
    localparam logic [7:0]  PM_BLANK        = 8'hFF;
    localparam int          FLASH_BYTES_DEF = 8192;
    localparam int          FLASH_BYTES_MIN = 1024;
    localparam int          FLASH_BYTES_MAX = 8192;

    // ****************
    // Information area layout (index inside the area)
    // ****************
    localparam int          INFO_BYTES      = 128;
    localparam logic [6:0]  INFO_CAL0_LAST  = 7'h3F;
    localparam logic [6:0]  INFO_ID_BASE    = 7'h40;
    localparam logic [6:0]  INFO_ID_LAST    = 7'h53;
    localparam logic [6:0]  INFO_CAL1_BASE  = 7'h60;
    localparam int          INFO_ID_CHARS   = 20;
    localparam int          INFO_CAL0_BYTES = 64;
    localparam int          INFO_CAL1_BYTES = 32;

    // ****************
    // Carrier types
    // ****************
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } mad_rf_req_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mad_pm_req_type;

    typedef struct packed {
        logic        valid;
        logic [7:0]  rdata;
    } mad_rsp_type;

    typedef enum logic [1:0] {
        RF_AREA_RAM,
        RF_AREA_HOLE,
        RF_AREA_CTL,
        RF_AREA_PSEL
    } mad_rf_area_type;

    typedef enum logic [3:0] {
        PM_AREA_OPTION,
        PM_AREA_RESET_VEC,
        PM_AREA_WDOG_VEC,
        PM_AREA_TRAP_VEC,
        PM_AREA_IRQ_VEC,
        PM_AREA_RESERVED,
        PM_AREA_OSC_VEC,
        PM_AREA_CODE,
        PM_AREA_INFO,
        PM_AREA_UNIMPL
    } mad_pm_area_type;

endpackage

// >>> src/mad_rf_ram.sv
// General-purpose register-file RAM, byte wide, from address zero up.
// Assumes the decoder gives it only in-range addresses.
`timescale 1ns/10ps
module mad_rf_ram #(
    parameter int DEPTH = 1024
) (
    input  wire logic                     clk_sys,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] addr,
    input  wire logic [7:0]               wdata,
    output logic      [7:0]               rdata
);

    // Contents are undefined after reset, so the array has no reset
    logic [7:0] mem [DEPTH];

    // ********************************************************
    // Write port
    // ********************************************************
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
    end

    // Read is combinational; the decoder registers the answer
    assign rdata = mem[addr];

endmodule

// >>> src/mad_info_rom.sv
// Factory information area: calibration bytes and the part identifier.
// Assumes contents are fixed at build time; no path writes it.
`timescale 1ns/10ps
module mad_info_rom
    import mad_pkg::*;
#(
    // Arbitrary neutral identifier, right-justified, length below
    parameter logic [159:0] PART_ID     = "GENERIC-MCU",
    parameter int           PART_ID_LEN = 11,
    parameter logic [511:0] CAL0_DATA   = '1,  // Blank unless given
    parameter logic [255:0] CAL1_DATA   = '1   // Blank unless given
) (
    input  wire logic [6:0] idx,
    output logic      [7:0] rdata
);

    generate
        if (PART_ID_LEN < 0 || PART_ID_LEN > INFO_ID_CHARS) begin : g_chk
            $error("mad_info_rom: PART_ID_LEN out of range");
        end
    endgenerate

    // ********************************************************
    // Read decode
    // ********************************************************
    always_comb begin
        int unsigned pos;
        pos   = 0;
        rdata = PM_BLANK;
        if (idx <= INFO_CAL0_LAST) begin
            rdata = CAL0_DATA[8*idx +: 8];
        end else if (idx >= INFO_ID_BASE && idx <= INFO_ID_LAST) begin
            // Left-aligned text, trailing positions read as blank
            pos = 32'(idx - INFO_ID_BASE);
            if (pos < PART_ID_LEN) begin
                rdata = PART_ID[8*(PART_ID_LEN-1-pos) +: 8];
            end else begin
                rdata = PM_BLANK;
            end
        end else if (idx >= INFO_CAL1_BASE) begin
            rdata = CAL1_DATA[8*(idx - INFO_CAL1_BASE) +: 8];
        end else begin
            rdata = PM_BLANK;   // Reserved gap between id and cal data
        end
    end

endmodule

// >>> src/mad_decoder.sv
// Memory address decoder: register file, program space, data space.
// Assumes one request per port per cycle, answered two edges later.
`timescale 1ns/10ps
module mad_decoder
    import mad_pkg::*;
#(
    parameter int RAM_BYTES   = RAM_BYTES_DEF,
    parameter int FLASH_BYTES = FLASH_BYTES_DEF
) (
    input  wire logic                     clk_sys,
    input  wire logic                     resetn,
    input  wire mad_pkg::mad_rf_req_type  rf_req,
    output mad_pkg::mad_rsp_type          rf_rsp,
    output mad_pkg::mad_rf_req_type       ctl_req,
    input  wire logic [7:0]               ctl_rdata,
    input  wire mad_pkg::mad_pm_req_type  pm_req,
    output mad_pkg::mad_rsp_type          pm_rsp,
    output mad_pkg::mad_pm_area_type      pm_area,
    input  wire mad_pkg::mad_pm_req_type  dm_req,
    output mad_pkg::mad_rsp_type          dm_rsp,
    output logic                          info_en
);

    import mad_pkg::*;

    localparam int RAM_AW   = $clog2(RAM_BYTES);
    localparam int FLASH_AW = $clog2(FLASH_BYTES);

    // ********************************************************
    // Elaboration checks
    // ********************************************************
    generate
        if (RAM_BYTES < RAM_BYTES_MIN || RAM_BYTES > RAM_BYTES_MAX ||
            (1 << RAM_AW) != RAM_BYTES) begin : g_ram_chk
            $error("mad_decoder: RAM_BYTES not served");
        end
        if (FLASH_BYTES < FLASH_BYTES_MIN ||
            FLASH_BYTES > FLASH_BYTES_MAX ||
            (1 << FLASH_AW) != FLASH_BYTES) begin : g_flash_chk
            $error("mad_decoder: FLASH_BYTES not served");
        end
    endgenerate

    // ********************************************************
    // Stage-one registers
    // ********************************************************
    mad_rf_req_type  rf_s1_reg;        // Register-file request held
    mad_rf_area_type rf_area_s1_reg;   // Its decoded area
    mad_pm_req_type  pm_s1_reg;        // Program request held
    logic            dm_s1_reg;        // Data-space request seen
    logic [7:0]      psel_reg;         // Flash page-select register

    // ********************************************************
    // Output registers
    // ********************************************************
    mad_rsp_type      rf_rsp_reg;
    mad_rsp_type      pm_rsp_reg;
    mad_pm_area_type  pm_area_reg;
    mad_rf_req_type   ctl_req_reg;
    mad_rsp_type      dm_rsp_reg;

    // Combinational helpers
    mad_rf_area_type  rf_area_next;    // Area of the incoming address
    mad_pm_area_type  pm_area_next;    // Area of the held program addr
    logic [7:0]       ram_rdata;       // RAM read data at stage one
    logic             ram_wr;          // RAM write strobe
    logic [7:0]       info_rdata;      // Information area read data
    logic [7:0]       flash_rdata;     // Flash array read data
    logic             pm_in_flash;     // Held address inside flash
    logic             pm_in_info;      // Held address in the overlay
    logic [7:0]       pm_rdata_next;   // Program answer before register
    logic [7:0]       rf_rdata_next;   // Register-file answer

    // Flash program store
    logic [7:0] flash_mem [FLASH_BYTES];

    // ********************************************************
    // Register-file decode
    // ********************************************************
    // Only the top 256 addresses, less the page select at FF9, reach control logic; everything
    // between RAM and that region is a hole.
    always_comb begin
        if (rf_req.addr >= RF_CTL_BASE) begin
            if (rf_req.addr == RF_PAGE_SEL) begin
                rf_area_next = RF_AREA_PSEL;
            end else begin
                rf_area_next = RF_AREA_CTL;
            end
        end else if (rf_req.addr < 12'(RAM_BYTES)) begin
            rf_area_next = RF_AREA_RAM;
        end else begin
            rf_area_next = RF_AREA_HOLE;
        end
    end

    // Capture the operand access the core issues
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rf_s1_reg      <= '0;
            rf_area_s1_reg <= RF_AREA_HOLE;
        end else begin
            rf_s1_reg      <= rf_req;
            rf_area_s1_reg <= rf_area_next;
        end
    end

    // ********************************************************
    // General-purpose RAM
    // ********************************************************
    // Writes reach the array only inside the RAM range, so a write
    // into the hole leaves every byte untouched.
    assign ram_wr = rf_s1_reg.valid && rf_s1_reg.write &&
                    (rf_area_s1_reg == RF_AREA_RAM);

    mad_rf_ram #(
        .DEPTH (RAM_BYTES)
    ) u_ram (
        .clk_sys (clk_sys),
        .wr_en   (ram_wr),
        .addr    (rf_s1_reg.addr[RAM_AW-1:0]),
        .wdata   (rf_s1_reg.wdata),
        .rdata   (ram_rdata)
    );

    // ********************************************************
    // Flash page-select register
    // ********************************************************
    // Cleared by reset so the overlay starts inactive.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            psel_reg <= PAGE_SEL_RESET;
        end else if (rf_s1_reg.valid && rf_s1_reg.write &&
                     rf_area_s1_reg == RF_AREA_PSEL) begin
            psel_reg <= rf_s1_reg.wdata;
        end
    end

    // Overlay enable straight from the register bit
    assign info_en = psel_reg[PAGE_SEL_INFO];

    // ********************************************************
    // Control-region forwarding
    // ********************************************************
    // Control accesses go out on the same edge as capture; the peripheral
    // side answers on ctl_rdata in that same cycle. Reserved control
    // addresses are forwarded too and their answer is undefined.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctl_req_reg <= '0;
        end else if (rf_req.valid && rf_area_next == RF_AREA_CTL) begin
            ctl_req_reg <= rf_req;
        end else begin
            ctl_req_reg <= '0;
        end
    end

    assign ctl_req = ctl_req_reg;

    // ********************************************************
    // Register-file answer
    // ********************************************************
    always_comb begin
        unique case (rf_area_s1_reg)
            RF_AREA_RAM:  rf_rdata_next = ram_rdata;
            RF_AREA_PSEL: rf_rdata_next = psel_reg;
            RF_AREA_CTL:  rf_rdata_next = ctl_rdata;
            RF_AREA_HOLE: rf_rdata_next = RF_UNDEF_VALUE;
        endcase
    end

    // Every request gets one answer, writes included
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rf_rsp_reg <= '0;
        end else begin
            rf_rsp_reg.valid <= rf_s1_reg.valid;
            rf_rsp_reg.rdata <= rf_rdata_next;
        end
    end

    assign rf_rsp = rf_rsp_reg;

    // ********************************************************
    // Program-space capture
    // ********************************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pm_s1_reg <= '0;
        end else begin
            pm_s1_reg <= pm_req;
        end
    end

    assign pm_in_flash = pm_s1_reg.addr < 16'(FLASH_BYTES);
    assign pm_in_info  = info_en &&
                         pm_s1_reg.addr >= PM_INFO_BASE &&
                         pm_s1_reg.addr <= PM_INFO_LAST;

    // ********************************************************
    // Program-space area decode
    // ********************************************************
    // Classified from the held address; the overlay wins over flash.
    always_comb begin
        if (pm_in_info) begin
            pm_area_next = PM_AREA_INFO;
        end else if (!pm_in_flash) begin
            pm_area_next = PM_AREA_UNIMPL;
        end else if (pm_s1_reg.addr >= PM_CODE_BASE) begin
            pm_area_next = PM_AREA_CODE;
        end else if (pm_s1_reg.addr >= PM_OSC_BASE) begin
            pm_area_next = PM_AREA_OSC_VEC;
        end else if (pm_s1_reg.addr >= PM_RSVD_BASE) begin
            pm_area_next = PM_AREA_RESERVED;
        end else if (pm_s1_reg.addr >= PM_IRQ_BASE) begin
            pm_area_next = PM_AREA_IRQ_VEC;
        end else if (pm_s1_reg.addr >= PM_TRAP_VEC) begin
            pm_area_next = PM_AREA_TRAP_VEC;
        end else if (pm_s1_reg.addr >= PM_WDOG_VEC) begin
            pm_area_next = PM_AREA_WDOG_VEC;
        end else if (pm_s1_reg.addr >= PM_RESET_VEC) begin
            pm_area_next = PM_AREA_RESET_VEC;
        end else begin
            pm_area_next = PM_AREA_OPTION;
        end
    end

    // ********************************************************
    // Flash store
    // ********************************************************
    // Stand-in write path for implemented flash; writes outside
    // flash or into the overlay window store nothing.
    always_ff @(posedge clk_sys) begin
        if (pm_s1_reg.valid && pm_s1_reg.write &&
            pm_in_flash && !pm_in_info) begin
            flash_mem[pm_s1_reg.addr[FLASH_AW-1:0]] <= pm_s1_reg.wdata;
        end
    end

    assign flash_rdata = flash_mem[pm_s1_reg.addr[FLASH_AW-1:0]];

    // ********************************************************
    // Information area
    // ********************************************************
    // The area is 128 bytes; the upper part of the overlay window
    // reads as blank.
    mad_info_rom u_info (
        .idx   (pm_s1_reg.addr[6:0]),
        .rdata (info_rdata)
    );

    always_comb begin
        if (pm_in_info) begin
            if (pm_s1_reg.addr < PM_INFO_BASE + 16'(INFO_BYTES)) begin
                pm_rdata_next = info_rdata;
            end else begin
                pm_rdata_next = PM_BLANK;
            end
        end else if (pm_in_flash) begin
            pm_rdata_next = flash_rdata;
        end else begin
            pm_rdata_next = PM_BLANK;
        end
    end

    // ********************************************************
    // Program-space answer
    // ********************************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pm_rsp_reg  <= '0;
            pm_area_reg <= PM_AREA_OPTION;
        end else begin
            pm_rsp_reg.valid <= pm_s1_reg.valid;
            pm_rsp_reg.rdata <= pm_rdata_next;
            pm_area_reg      <= pm_area_next;
        end
    end

    assign pm_rsp  = pm_rsp_reg;
    assign pm_area = pm_area_reg;

    // ********************************************************
    // Data-only space
    // ********************************************************
    // Nothing stores here: requests are answered so the core never
    // stalls, but the data is blank and writes are dropped.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dm_s1_reg  <= 1'b0;
            dm_rsp_reg <= '0;
        end else begin
            dm_s1_reg        <= dm_req.valid;
            dm_rsp_reg.valid <= dm_s1_reg;
            dm_rsp_reg.rdata <= PM_BLANK;
        end
    end

    assign dm_rsp = dm_rsp_reg;

endmodule

// >>> bench/mad_ctl_model.sv
// Stand-in for the control registers that sit behind the decoder.
// Assumes one forwarded access per cycle; answers in the same cycle.
`timescale 1ns/10ps
module mad_ctl_model (
    input  wire mad_pkg::mad_rf_req_type ctl_req,
    output logic      [7:0]              ctl_rdata
);
    import mad_pkg::*;

    // Reply is a fixed function of the address, so the bench predicts it;
    // idle cycles show its inverse, so a stale capture is caught
    always_comb begin
        ctl_rdata = ctl_req.addr[7:0] ^ 8'h5A;
        if (!ctl_req.valid) begin
            ctl_rdata = ~ctl_rdata;
        end
    end
endmodule

// >>> bench/mad_decoder_monitor.sv
// Port checker for the memory address decoder.
// Assumes it is bound into mad_decoder and sees only its ports.
`timescale 1ns/10ps
module mad_decoder_monitor
    import mad_pkg::*;
#(
    parameter int RAM_BYTES   = RAM_BYTES_DEF,
    parameter int FLASH_BYTES = FLASH_BYTES_DEF
) (
    input wire logic                     clk_sys,
    input wire logic                     resetn,
    input wire mad_pkg::mad_rf_req_type  rf_req,
    input wire mad_pkg::mad_rsp_type     rf_rsp,
    input wire mad_pkg::mad_rf_req_type  ctl_req,
    input wire logic [7:0]               ctl_rdata,
    input wire mad_pkg::mad_pm_req_type  pm_req,
    input wire mad_pkg::mad_rsp_type     pm_rsp,
    input wire mad_pkg::mad_pm_area_type pm_area,
    input wire mad_pkg::mad_pm_req_type  dm_req,
    input wire mad_pkg::mad_rsp_type     dm_rsp,
    input wire logic                     info_en
);
    import mad_pkg::*;
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    logic psel_wr;                       // Page-select write at the port
    assign psel_wr = rf_req.valid && rf_req.write &&
                     rf_req.addr == RF_PAGE_SEL;

    property p_rf_answer;
        rf_req.valid |-> ##2 rf_rsp.valid;
    endproperty
    a_rf_answer: assert property (p_rf_answer) else $error("rf no answer");
    property p_ctl_fwd;
        rf_req.valid && rf_req.addr >= RF_CTL_BASE
        && rf_req.addr != RF_PAGE_SEL
        |=> ctl_req.valid && ctl_req.addr == $past(rf_req.addr);
    endproperty
    a_ctl_fwd: assert property (p_ctl_fwd) else $error("ctl not fwd");
    property p_low_local;
        rf_req.valid && rf_req.addr < RF_CTL_BASE |=> !ctl_req.valid;
    endproperty
    a_low_local: assert property (p_low_local) else $error("low fwd");
    property p_ctl_data;
        ctl_req.valid && !ctl_req.write
        |=> rf_rsp.valid && rf_rsp.rdata == $past(ctl_rdata);
    endproperty
    a_ctl_data: assert property (p_ctl_data) else $error("ctl data");
    property p_hole;
        rf_req.valid && !rf_req.write && rf_req.addr >= RAM_BYTES
        && rf_req.addr < RF_CTL_BASE |-> ##2 rf_rsp.rdata == RF_UNDEF_VALUE;
    endproperty
    a_hole: assert property (p_hole) else $error("hole read");
    property p_unimpl;
        pm_req.valid && !pm_req.write && pm_req.addr >= FLASH_BYTES
        && pm_req.addr < PM_INFO_BASE
        |-> ##2 pm_rsp.rdata == PM_BLANK && pm_area == PM_AREA_UNIMPL;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimpl read");
    property p_overlay;
        pm_req.valid && !pm_req.write && pm_req.addr >= 16'hFE80
        && pm_req.addr <= PM_INFO_LAST ##1 info_en
        |-> ##1 pm_rsp.rdata == PM_BLANK && pm_area == PM_AREA_INFO;
    endproperty
    a_overlay: assert property (p_overlay) else $error("overlay pad");
    property p_dm;
        dm_req.valid |-> ##2 dm_rsp.valid && dm_rsp.rdata == PM_BLANK;
    endproperty
    a_dm: assert property (p_dm) else $error("data space");
    property p_psel;
        $changed(info_en) |-> $past(psel_wr) || $past(psel_wr, 2);
    endproperty
    a_psel: assert property (p_psel) else $error("info_en moved");
    property p_reset;
        $rose(resetn) |-> !info_en && !rf_rsp.valid;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state");

    // Main scenarios reached
    c_ctl: cover property (ctl_req.valid && !ctl_req.write);
    c_info: cover property (info_en && pm_req.valid);
    c_dm: cover property (dm_req.valid);
endmodule

bind mad_decoder mad_decoder_monitor #(
    .RAM_BYTES(RAM_BYTES), .FLASH_BYTES(FLASH_BYTES)
) u_monitor (
    .clk_sys(clk_sys), .resetn(resetn), .rf_req(rf_req), .rf_rsp(rf_rsp),
    .ctl_req(ctl_req), .ctl_rdata(ctl_rdata), .pm_req(pm_req),
    .pm_rsp(pm_rsp), .pm_area(pm_area), .dm_req(dm_req), .dm_rsp(dm_rsp),
    .info_en(info_en)
);

// >>> bench/memory_address_decoder_test.sv
// Self-checking bench for the memory address decoder.
// Assumes the control-register model answers forwarded accesses.
`timescale 1ns/10ps
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin \
    bad_count++; $display("ERROR %0t: got %h want %h", $time, act, exp); end end
module memory_address_decoder_test;
    import mad_pkg::*;
    localparam int RAM_B = 256;          // Smallest RAM, boundary at 0FF
    localparam int FL_B  = 1024;         // Smallest flash, boundary at 3FF
    logic clk_sys, resetn, info_en;      // Clock, reset, overlay flag
    mad_rf_req_type  rf_req, ctl_req;    // Register-file side
    mad_pm_req_type  pm_req, dm_req;     // Program and data spaces
    mad_rsp_type     rf_rsp, pm_rsp, dm_rsp;
    mad_pm_area_type pm_area;            // Area of the program answer
    logic [7:0]  ctl_rdata, d;           // Peripheral byte, random byte
    logic [12:0] rf_q[$], pm_q[$], dm_q[$], ex; // {check, area, data}
    int bad_count, comparisons, i;
    string id = "GENERIC-MCU";           // Default identifier, 11 chars
    logic [15:0] va[9] = '{16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0008,
        16'h0038, 16'h003A, 16'h003E, 16'h03FF};
    mad_pm_area_type vt[9] = '{PM_AREA_OPTION, PM_AREA_RESET_VEC,
        PM_AREA_WDOG_VEC, PM_AREA_TRAP_VEC, PM_AREA_IRQ_VEC, PM_AREA_RESERVED,
        PM_AREA_OSC_VEC, PM_AREA_CODE, PM_AREA_CODE};
    logic [15:0] pad[7] = '{16'hFE00, 16'hFE3F, 16'hFE54, 16'hFE60, 16'hFE7F,
        16'hFE80, 16'hFF7F};             // Blank calibration and reserved

    mad_decoder #(.RAM_BYTES(RAM_B), .FLASH_BYTES(FL_B)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .rf_req(rf_req), .rf_rsp(rf_rsp),
        .ctl_req(ctl_req), .ctl_rdata(ctl_rdata), .pm_req(pm_req),
        .pm_rsp(pm_rsp), .pm_area(pm_area), .dm_req(dm_req),
        .dm_rsp(dm_rsp), .info_en(info_en));
    mad_ctl_model u_ctl (.ctl_req(ctl_req), .ctl_rdata(ctl_rdata));

    // ****************
    // Clock and drivers
    // ****************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Each op holds its request one edge and notes its answer
    task automatic rf_op(input logic w, input logic [11:0] a,
        input logic [7:0] wd, input logic c = 1'b0,
        input logic [7:0] e = 8'h00);
        @(posedge clk_sys);
        rf_req <= '{1'b1, w, a, wd};
        pm_req.valid <= 1'b0;
        rf_q.push_back({c, 4'h0, e});
    endtask
    task automatic pm_op(input logic w, input logic [15:0] a,
        input logic [7:0] wd, input logic c = 1'b0,
        input mad_pm_area_type ar = PM_AREA_CODE, input logic [7:0] e = 8'h00);
        @(posedge clk_sys);
        pm_req <= '{1'b1, w, a, wd};
        rf_req.valid <= 1'b0;
        pm_q.push_back({c, ar, e});
    endtask
    // Idle the ports and wait, bounded, for every noted answer
    task automatic end_test(input string n);
        @(posedge clk_sys);
        rf_req.valid <= 1'b0;
        pm_req.valid <= 1'b0;
        dm_req.valid <= 1'b0;
        for (i = 0; i < 20 && rf_q.size() + pm_q.size() + dm_q.size() > 0; i++)
            @(posedge clk_sys);
        if (i == 20) begin
            bad_count++;
            $display("ERROR %0t: answers missing", $time);
            print_verdict();
        end
        $display("Test %s done", n);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Scoreboard: oldest note against each answer; sampled before updates
    always @(posedge clk_sys) begin
        if (rf_rsp.valid) begin
            ex = rf_q.size() ? rf_q.pop_front() : '1;
            if (ex[12]) `CHK(rf_rsp.rdata, ex[7:0])
        end
        if (pm_rsp.valid) begin
            ex = pm_q.size() ? pm_q.pop_front() : '1;
            if (ex[12]) `CHK({pm_area, pm_rsp.rdata}, ex[11:0])
        end
        if (dm_rsp.valid) begin
            ex = dm_q.size() ? dm_q.pop_front() : '1;
            `CHK(dm_rsp.rdata, ex[7:0])
        end
    end

    // ****************
    // Scenarios
    // ****************
    initial begin
        rf_req = '0; pm_req = '0; dm_req = '0; resetn = 1'b0;
        void'($urandom(32'h842E20D0));
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        end_test("reset");
        `CHK(info_en, 1'b0)
        d = $urandom;
        rf_op(1'b1, 12'h0FF, d);
        rf_op(0, 12'h0FF, 0, 1, d);
        rf_op(1'b1, 12'h000, ~d);
        rf_op(1'b1, 12'h100, d);
        rf_op(0, 12'h000, 0, 1, ~d);
        rf_op(0, 12'h100, 0, 1, RF_UNDEF_VALUE);
        rf_op(0, 12'hEFF, 0, 1, RF_UNDEF_VALUE);
        rf_op(0, 12'hF41, 0, 1, 8'h41 ^ 8'h5A);
        rf_op(0, 12'hFF0, 0, 1, 8'hF0 ^ 8'h5A);
        rf_op(1'b1, 12'hF05, d);
        end_test("register file");
        for (i = 0; i < 9; i++) begin
            d = $urandom;
            pm_op(1'b1, va[i], d);
            pm_op(0, va[i], 0, 1, vt[i], d);
        end
        pm_op(1'b1, 16'h0005, 8'h3C);
        pm_op(1'b1, 16'h0405, 8'hC3);
        pm_op(0, 16'h0005, 0, 1, PM_AREA_WDOG_VEC, 8'h3C);
        pm_op(0, 16'h0400, 0, 1, PM_AREA_UNIMPL, PM_BLANK);
        pm_op(0, 16'hFE40, 0, 1, PM_AREA_UNIMPL, PM_BLANK);
        end_test("program space");
        for (i = 0; i < 2; i++) begin
            @(posedge clk_sys);
            dm_req <= '{1'b1, i[0], 16'($urandom), 8'($urandom)};
            dm_q.push_back({1'b1, 4'h0, PM_BLANK});
        end
        end_test("data space");
        rf_op(1'b1, RF_PAGE_SEL, 8'h80);
        rf_op(0, RF_PAGE_SEL, 0, 1, 8'h80);
        end_test("page select");
        `CHK(info_en, 1'b1)
        for (i = 0; i < 20; i++)
            pm_op(0, 16'hFE40 + 16'(i), 0, 1, PM_AREA_INFO,
                (i < id.len()) ? id[i] : PM_BLANK);
        for (i = 0; i < 7; i++)
            pm_op(0, pad[i], 0, 1, PM_AREA_INFO, PM_BLANK);
        pm_op(1'b1, 16'hFE40, 8'h00);
        pm_op(0, 16'hFE40, 0, 1, PM_AREA_INFO, id[0]);
        pm_op(0, 16'hFF80, 0, 1, PM_AREA_UNIMPL, PM_BLANK);
        rf_op(1'b1, RF_PAGE_SEL, 8'h7F);
        end_test("overlay");
        `CHK(info_en, 1'b0)
        rf_op(1'b1, RF_PAGE_SEL, 8'h80);
        end_test("enable again");
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        end_test("second reset");
        `CHK(info_en, 1'b0)
        print_verdict();
    end
endmodule
